/* File: dv/uwas_bus_model.sv */
// Bus-side partner: line levels, tokens and engine stall pulses
`timescale 1ns/1ns
`default_nettype none
module uwas_bus_model
	import uwas_pkg::*;
(
	input  wire logic              ref_clk,
	output uwas_lines_t            lines,
	output uwas_tok_t              tok,
	output logic [UWAS_NUM_EP-1:0] sie_stall_set
);
	// Idle levels: dp high, others low, no token
	initial begin
		lines = 4'h8;
		tok = '0;
		sie_stall_set = '0;
	end

	// Flip one line of {dp,dm,vbus,id}; ID moves only on command
	task toggle(input int i);
		@(posedge ref_clk);
		lines <= lines ^ (4'h1 << i);
	endtask : toggle

	// One-cycle token toward the block
	task token(input logic [3:0] ep, input logic is_in);
		@(posedge ref_clk);
		tok <= '{1'b1, is_in, ep};
		@(posedge ref_clk);
		tok <= '0;
	endtask : token

	// Engine raises one endpoint stall for a cycle
	task engine_stall(input int ep);
		@(posedge ref_clk);
		sie_stall_set <= 16'h1 << ep;
		@(posedge ref_clk);
		sie_stall_set <= '0;
	endtask : engine_stall
endmodule : uwas_bus_model
`default_nettype wire

/* File: dv/uwas_top_tb.sv */
// Testbench of the wake and stall block
`timescale 1ns/1ns
`default_nettype none
module uwas_top_tb
	import uwas_pkg::*;
;
	logic                   ref_clk, nrst, psel, penable, pwrite, pready, pslverr, hs_valid, wake, irq;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata;
	uwas_lines_t            lines;
	uwas_tok_t              tok;
	logic [UWAS_NUM_EP-1:0] sie_stall_set;
	uwas_hs_t               hs_code;
	int                     fails, n_checks, ep;
	logic [31:0]            exp_rd[$];
	uwas_hs_t               exp_hs[$];

	uwas_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.lines(lines), .tok(tok), .sie_stall_set(sie_stall_set), .hs_valid(hs_valid),
		.hs_code(hs_code), .wake(wake), .irq(irq));
	uwas_bus_model model_u (.ref_clk(ref_clk), .lines(lines), .tok(tok), .sie_stall_set(sie_stall_set));

	initial begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// APB transfer; d is write data or expected read data
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) exp_rd.push_back(d);
		@(posedge ref_clk);
		chk("pready", 1, pready);
		penable <= 1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		chk("pslverr", {31'h0, a > UWAS_OFF_LINES}, {31'h0, pslverr});
		psel <= 0;
		penable <= 0;
	endtask : apb

	// Token with its expected handshake, none left pending after
	task tk(input logic [3:0] e_ep, input logic in, input uwas_hs_t e);
		exp_hs.push_back(e);
		model_u.token(e_ep, in);
		repeat (2) @(posedge ref_clk);
		chk("hs_pending", 0, exp_hs.size());
	endtask : tk

	// Watcher takes the oldest note whenever a result appears
	always @(posedge ref_clk) begin
		if (psel && penable && !pwrite && pready) chk("prdata", exp_rd.pop_front(), prdata);
		if (hs_valid === 1'b1) begin
			if (exp_hs.size() == 0) chk("hs_valid", 0, 1);
			else chk("hs_code", 32'(exp_hs.pop_front()), 32'(hs_code));
		end
	end

	task give_verdict;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		give_verdict;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		fails = 0;
		n_checks = 0;
		void'($urandom(32'hcc1e));
		repeat (20) @(posedge ref_clk);
		nrst <= 1;
		apb(0, UWAS_OFF_CTRL, 0);
		apb(0, 8'h1c, 0);
		apb(1, 8'h1c, 32'hffff_ffff);
		// Awake: dp sets nothing, ID sets only its own flag
		model_u.toggle(3);
		model_u.toggle(0);
		repeat (3) @(posedge ref_clk);
		chk("wake", 0, wake);
		apb(0, UWAS_OFF_STATUS, 32'h80);
		apb(1, UWAS_OFF_STATUS, 32'hff);
		apb(1, UWAS_OFF_MASK, 32'h10);
		apb(1, UWAS_OFF_CTRL, 32'h6);
		// Sleeping: dp, dm, vbus each wake and interrupt
		for (int i = 1; i < 4; i++) begin
			model_u.toggle(i);
			repeat (3) @(posedge ref_clk);
			chk("wake", 1, wake);
			chk("irq", 1, irq);
			apb(0, UWAS_OFF_STATUS, 32'h10);
			apb(1, UWAS_OFF_STATUS, 32'h10);
			@(posedge ref_clk);
			chk("irq", 0, irq);
		end
		model_u.toggle(0);
		repeat (20) @(posedge ref_clk);
		apb(0, UWAS_OFF_STATUS, 32'h90);
		apb(1, UWAS_OFF_STATUS, 32'h90);
		apb(1, UWAS_OFF_CTRL, 0);
		repeat (2) @(posedge ref_clk);
		chk("wake", 0, wake);
		chk("irq", 0, irq);
		// Stall on every endpoint from each source
		apb(1, UWAS_OFF_OWNER, 32'hffff);
		for (ep = 0; ep < UWAS_NUM_EP; ep++) begin
			apb(1, UWAS_OFF_ENDPOINT_STALL_CONTROL, 32'h1 << ep);
			tk(ep[3:0], 1, UWAS_HS_STALL);
			tk(ep[3:0], 0, UWAS_HS_STALL);
			apb(1, UWAS_OFF_ENDPOINT_STALL_CONTROL, 0);
			model_u.engine_stall(ep);
			tk(ep[3:0], 1, UWAS_HS_STALL);
			apb(0, UWAS_OFF_ENDPOINT_STALL_CONTROL, 32'h1 << ep);
			apb(1, UWAS_OFF_DSTALL, 32'h1 << ep);
			apb(1, UWAS_OFF_ENDPOINT_STALL_CONTROL, 0);
			tk(ep[3:0], 0, UWAS_HS_STALL);
			apb(1, UWAS_OFF_DSTALL, 0);
			tk(ep[3:0], 1'($urandom), UWAS_HS_ACK);
		end
		apb(1, UWAS_OFF_OWNER, 0);
		apb(1, UWAS_OFF_ENDPOINT_STALL_CONTROL, 32'h1);
		tk(0, 1, UWAS_HS_NAK);
		// Host mode: the watcher flags any handshake
		apb(1, UWAS_OFF_CTRL, 32'h1);
		apb(1, UWAS_OFF_OWNER, 32'hffff);
		model_u.token(0, 1);
		repeat (3) @(posedge ref_clk);
		give_verdict;
	end
endmodule : uwas_top_tb
`default_nettype wire

/* File: rtl/uwas_line_watch.sv */
// Line watcher: registers bus lines and reports level changes
`timescale 1ns/1ns
`default_nettype none
module uwas_line_watch
	import uwas_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire uwas_lines_t lines,
	output logic             bus_change,
	output logic             id_change,
	output uwas_lines_t      lines_q
);

	uwas_lines_t lines_d;
	logic        seen_q;
	logic        seen_d;

	// Next state: capture lines, remember first sample after reset
	always_comb begin
		lines_d = lines;
		seen_d  = 1'b1;
	end

	// Registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lines_q <= '0;
			seen_q  <= 1'b0;
		end else begin
			lines_q <= lines_d;
			seen_q  <= seen_d;
		end
	end

	// Change detect, muted until a first sample is held
	always_comb begin
		bus_change = seen_q && ((lines.dp != lines_q.dp) || (lines.dm != lines_q.dm) ||
			(lines.vbus != lines_q.vbus));
		id_change  = seen_q && (lines.id != lines_q.id);
	end

endmodule : uwas_line_watch
`default_nettype wire

/* File: rtl/uwas_pkg.sv */
// Package: register map, field layout and shared types of the wake and stall block
package uwas_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] UWAS_OFF_STATUS  = 8'h00; // Sticky event flags, write one to clear
	localparam logic [7:0] UWAS_OFF_MASK    = 8'h04; // Interrupt mask, same layout
	localparam logic [7:0] UWAS_OFF_CTRL    = 8'h08; // Mode and wake enable
	localparam logic [7:0] UWAS_OFF_ENDPOINT_STALL_CONTROL = 8'h0c; // Endpoint stall control bits
	localparam logic [7:0] UWAS_OFF_OWNER   = 8'h10; // Descriptor owner bits
	localparam logic [7:0] UWAS_OFF_DSTALL  = 8'h14; // Descriptor stall enable bits
	localparam logic [7:0] UWAS_OFF_LINES   = 8'h18; // Live line levels

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int UWAS_ST_ACT_BIT   = 4;  // Bus activity flag
	localparam int UWAS_ST_ID_BIT    = 7;  // ID change flag
	localparam int UWAS_CT_HOST_BIT  = 0;  // Host mode select
	localparam int UWAS_CT_WAKE_BIT  = 1;  // Activity wake enable
	localparam int UWAS_CT_SLEEP_BIT = 2;  // Core sleeping
	localparam int UWAS_NUM_EP       = 16; // Control endpoint plus 1..15

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  UWAS_STATUS_RST = 8'h00;
	localparam logic [7:0]  UWAS_MASK_RST   = 8'h00;
	localparam logic [2:0]  UWAS_CTRL_RST   = 3'h0;
	localparam logic [15:0] UWAS_EP_RST     = 16'h0000;
	localparam logic [31:0] UWAS_RDATA_RST  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic dp;
		logic dm;
		logic vbus;
		logic id;
	} uwas_lines_t;

	typedef struct packed {
		logic       valid; // One-cycle token request from the engine
		logic       is_in; // IN token when high, OUT otherwise
		logic [3:0] ep;    // Endpoint number
	} uwas_tok_t;

	typedef enum logic [1:0] {
		UWAS_HS_ACK,
		UWAS_HS_NAK,
		UWAS_HS_STALL
	} uwas_hs_t;

endpackage : uwas_pkg

/* File: rtl/uwas_stall_resp.sv */
// Stall responder: picks the handshake for a token
`timescale 1ns/1ns
`default_nettype none
module uwas_stall_resp
	import uwas_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	input  wire uwas_tok_t              tok,
	input  wire logic                   host_mode,
	input  wire logic [UWAS_NUM_EP-1:0] ep_stall,
	input  wire logic [UWAS_NUM_EP-1:0] owner,
	input  wire logic [UWAS_NUM_EP-1:0] dstall,
	output logic                        hs_valid,
	output uwas_hs_t                    hs_code
);

	logic     hs_valid_d;
	uwas_hs_t hs_code_d;
	logic     stall_hit;

	// Stall when either stall source is set and controller owns the buffer
	always_comb begin
		stall_hit  = (ep_stall[tok.ep] || dstall[tok.ep]) && owner[tok.ep];
		hs_valid_d = tok.valid && !host_mode;
		if (stall_hit) begin
			hs_code_d = UWAS_HS_STALL;
		end else if (owner[tok.ep]) begin
			hs_code_d = UWAS_HS_ACK;
		end else begin
			hs_code_d = UWAS_HS_NAK;
		end
	end

	// Answer registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			hs_valid <= 1'b0;
			hs_code  <= UWAS_HS_ACK;
		end else begin
			hs_valid <= hs_valid_d;
			hs_code  <= hs_code_d;
		end
	end

endmodule : uwas_stall_resp
`default_nettype wire

/* File: rtl/uwas_top.sv */
// Top: wake activity flags, endpoint stall control and APB register file
// Contract
// - Sleeping, line change sets bus activity flag
// - ID pin change also sets activity flag
// - Enabled activity flag wakes the core
// - ID change sets separate ID flag
// - Stall bit is both status and control
// - Engine or firmware may set stall bit
// - Stall plus owner answers STALL both directions
// - Stall control on endpoints zero through fifteen
// - Host mode never sends STALL
`timescale 1ns/1ns
`default_nettype none
module uwas_top
	import uwas_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic [31:0]                 prdata,
	input  wire uwas_lines_t            lines,
	input  wire uwas_tok_t              tok,
	input  wire logic [UWAS_NUM_EP-1:0] sie_stall_set,
	output logic                        hs_valid,
	output uwas_hs_t                    hs_code,
	output logic                        wake,
	output logic                        irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]             status_q, status_d;
	logic [7:0]             mask_q, mask_d;
	logic [2:0]             ctrl_q, ctrl_d;
	logic [UWAS_NUM_EP-1:0] ep_stall_q, ep_stall_d;
	logic [UWAS_NUM_EP-1:0] owner_q, owner_d;
	logic [UWAS_NUM_EP-1:0] dstall_q, dstall_d;
	logic [31:0]            prdata_d;
	logic                   wake_q, wake_d;
	logic                   bus_change;
	logic                   id_change;
	uwas_lines_t            lines_q;
	logic                   wr_en;
	logic                   rd_en;
	logic                   addr_ok;
	logic                   sleeping;
	logic                   host_mode;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------

	// Line change detector
	uwas_line_watch u_watch (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.lines      (lines),
		.bus_change (bus_change),
		.id_change  (id_change),
		.lines_q    (lines_q)
	);

	// Handshake chooser
	uwas_stall_resp u_resp (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.tok       (tok),
		.host_mode (host_mode),
		.ep_stall  (ep_stall_q),
		.owner     (owner_q),
		.dstall    (dstall_q),
		.hs_valid  (hs_valid),
		.hs_code   (hs_code)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------

	// Zero wait state slave; unmapped addresses answer with an error
	always_comb begin
		sleeping  = ctrl_q[UWAS_CT_SLEEP_BIT];
		host_mode = ctrl_q[UWAS_CT_HOST_BIT];
		addr_ok   = (paddr == UWAS_OFF_STATUS) || (paddr == UWAS_OFF_MASK) ||
			(paddr == UWAS_OFF_CTRL) || (paddr == UWAS_OFF_ENDPOINT_STALL_CONTROL) ||
			(paddr == UWAS_OFF_OWNER) || (paddr == UWAS_OFF_DSTALL) ||
			(paddr == UWAS_OFF_LINES);
		pready    = 1'b1;
		pslverr   = psel && penable && !addr_ok;
		wr_en     = psel && penable && pwrite && addr_ok;
		rd_en     = psel && !penable && !pwrite;
	end

	// ----------------------------------------------------------------
	// Flags and control
	// ----------------------------------------------------------------

	// Next values: firmware writes first, hardware sets win afterwards
	always_comb begin
		status_d   = status_q;
		mask_d     = mask_q;
		ctrl_d     = ctrl_q;
		ep_stall_d = ep_stall_q;
		owner_d    = owner_q;
		dstall_d   = dstall_q;
		if (wr_en) begin
			case (paddr)
				UWAS_OFF_STATUS: begin
					status_d = status_q & ~pwdata[7:0];
				end
				UWAS_OFF_MASK: begin
					mask_d = pwdata[7:0];
				end
				UWAS_OFF_CTRL: begin
					ctrl_d = pwdata[2:0];
				end
				UWAS_OFF_ENDPOINT_STALL_CONTROL: begin
					ep_stall_d = pwdata[UWAS_NUM_EP-1:0];
				end
				UWAS_OFF_OWNER: begin
					owner_d = pwdata[UWAS_NUM_EP-1:0];
				end
				UWAS_OFF_DSTALL: begin
					dstall_d = pwdata[UWAS_NUM_EP-1:0];
				end
				default: begin
					status_d = status_q;
				end
			endcase
		end
		// Activity while asleep on data lines or ID pin
		if (sleeping && (bus_change || id_change)) begin
			status_d[UWAS_ST_ACT_BIT] = 1'b1;
		end
		if (id_change) begin
			status_d[UWAS_ST_ID_BIT] = 1'b1;
		end
		// Engine stall sets apply to every endpoint and beat a firmware clear
		ep_stall_d = ep_stall_d | sie_stall_set;
	end

	// Registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			status_q   <= UWAS_STATUS_RST;
			mask_q     <= UWAS_MASK_RST;
			ctrl_q     <= UWAS_CTRL_RST;
			ep_stall_q <= UWAS_EP_RST;
			owner_q    <= UWAS_EP_RST;
			dstall_q   <= UWAS_EP_RST;
		end else begin
			status_q   <= status_d;
			mask_q     <= mask_d;
			ctrl_q     <= ctrl_d;
			ep_stall_q <= ep_stall_d;
			owner_q    <= owner_d;
			dstall_q   <= dstall_d;
		end
	end

	// ----------------------------------------------------------------
	// Wake, interrupt, read data
	// ----------------------------------------------------------------

	// Wake while the activity flag is set and enabled as a source
	always_comb begin
		wake_d = status_q[UWAS_ST_ACT_BIT] && ctrl_q[UWAS_CT_WAKE_BIT];
		irq    = |(status_q & mask_q);
	end

	// Read mux, captured in setup so data is registered in the access phase
	always_comb begin
		prdata_d = prdata;
		if (rd_en) begin
			case (paddr)
				UWAS_OFF_STATUS:  prdata_d = {24'h000000, status_q};
				UWAS_OFF_MASK:    prdata_d = {24'h000000, mask_q};
				UWAS_OFF_CTRL:    prdata_d = {29'h0000000, ctrl_q};
				UWAS_OFF_ENDPOINT_STALL_CONTROL: prdata_d = {16'h0000, ep_stall_q};
				UWAS_OFF_OWNER:   prdata_d = {16'h0000, owner_q};
				UWAS_OFF_DSTALL:  prdata_d = {16'h0000, dstall_q};
				UWAS_OFF_LINES:   prdata_d = {28'h0000000, lines_q};
				default:          prdata_d = UWAS_RDATA_RST;
			endcase
		end
	end

	// Output registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			prdata <= UWAS_RDATA_RST;
			wake_q <= 1'b0;
		end else begin
			prdata <= prdata_d;
			wake_q <= wake_d;
		end
	end

	assign wake = wake_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	sleep_act_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sleeping && bus_change) |=> status_q[UWAS_ST_ACT_BIT])
		else $error("activity flag not set on line change in sleep");

	id_act_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sleeping && id_change) |=> status_q[UWAS_ST_ACT_BIT] && status_q[UWAS_ST_ID_BIT])
		else $error("ID change in sleep did not set flags");

	wake_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(status_q[UWAS_ST_ACT_BIT] && ctrl_q[UWAS_CT_WAKE_BIT]) |=> wake)
		else $error("wake missing");

	id_flag_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		id_change |=> status_q[UWAS_ST_ID_BIT])
		else $error("ID flag not set");

	stall_resp_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(tok.valid && !host_mode && ep_stall_q[tok.ep] && owner_q[tok.ep] && $stable(ep_stall_q))
		|=> hs_valid && hs_code == UWAS_HS_STALL)
		else $error("stalled endpoint did not answer STALL");

	sie_stall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		|sie_stall_set |=> ((ep_stall_q & $past(sie_stall_set)) == $past(sie_stall_set)))
		else $error("engine stall set lost");

	host_no_hs_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		host_mode && $stable(host_mode) |-> !hs_valid)
		else $error("handshake issued in host mode");

	flag_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(status_q[UWAS_ST_ACT_BIT] && !(wr_en && paddr == UWAS_OFF_STATUS))
		|=> status_q[UWAS_ST_ACT_BIT])
		else $error("activity flag dropped without a clear");

	// Wake flags: nothing sets activity while awake, clears and holds behave
	awake_no_act_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!sleeping && !status_q[UWAS_ST_ACT_BIT]) |=> !status_q[UWAS_ST_ACT_BIT])
		else $error("activity flag set while awake");

	id_awake_only_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!sleeping && id_change && !status_q[UWAS_ST_ACT_BIT])
		|=> status_q[UWAS_ST_ID_BIT] && !status_q[UWAS_ST_ACT_BIT])
		else $error("ID change while awake set the wrong flags");

	wake_drop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(status_q[UWAS_ST_ACT_BIT] && ctrl_q[UWAS_CT_WAKE_BIT]) |=> !wake)
		else $error("wake without an enabled activity flag");

	flag_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wr_en && paddr == UWAS_OFF_STATUS && pwdata[UWAS_ST_ACT_BIT] &&
		!(sleeping && (bus_change || id_change))) |=> !status_q[UWAS_ST_ACT_BIT])
		else $error("activity flag not cleared by write one");

	id_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(status_q[UWAS_ST_ID_BIT] && !(wr_en && paddr == UWAS_OFF_STATUS)) |=> status_q[UWAS_ST_ID_BIT])
		else $error("ID flag dropped without a clear");

	// Stall answers: descriptor stall, owner gate, token pairing
	dstall_resp_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(tok.valid && !host_mode && dstall_q[tok.ep] && owner_q[tok.ep]) |=> hs_valid && hs_code == UWAS_HS_STALL)
		else $error("descriptor stall did not answer STALL");

	no_stall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(tok.valid && !host_mode && !ep_stall_q[tok.ep] && !dstall_q[tok.ep]) |=> hs_valid && hs_code != UWAS_HS_STALL)
		else $error("STALL sent with both stall bits clear");

	owner_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(tok.valid && !host_mode && !owner_q[tok.ep]) |=> hs_valid && hs_code == UWAS_HS_NAK)
		else $error("endpoint without owner did not answer NAK");

	dev_answer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(tok.valid && !host_mode) |=> hs_valid)
		else $error("device mode token left unanswered");

	no_token_hs_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(tok.valid && !host_mode) |=> !hs_valid)
		else $error("handshake without a device mode token");

	stall_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(wr_en && paddr == UWAS_OFF_ENDPOINT_STALL_CONTROL) |=> ((ep_stall_q & $past(ep_stall_q)) == $past(ep_stall_q)))
		else $error("stall bit dropped without a firmware write");

	// Firmware stall set lands on every endpoint
	for (genvar g = 0; g < UWAS_NUM_EP; g++) begin : g_ep_chk
		fw_stall_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
			(wr_en && paddr == UWAS_OFF_ENDPOINT_STALL_CONTROL && pwdata[g]) |=> ep_stall_q[g])
			else $error("firmware stall set lost");
	end

endmodule : uwas_top
`default_nettype wire
